// ### rtl/dap_defines.svh
// Constants for the AXI4 write/read master that drives one DDR port
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH
// ****************************************
// Link field widths
// ****************************************
`define DAP_ADDR_W    33
`define DAP_DATA_W    512
`define DAP_STRB_W    64
`define DAP_ID_W      6
`define DAP_LEN_W     8
`define DAP_SIZE_W    3
`define DAP_QOS_W     4
`define DAP_CACHE_W   4
`define DAP_RESP_W    2
`define DAP_PAT_REP   16
// ****************************************
// Burst codes and limits
// ****************************************
`define DAP_BURST_INCR      2'h1
`define DAP_BURST_WRAP      2'h2
`define DAP_ALLSTRB_MAX_LEN 8'h0F
// ****************************************
// Link clock: half period in clk_i cycles
// ****************************************
`define DAP_ACLK_HALF 4
`define DAP_PH_W      4
`define DAP_SYNC_W    12
// ****************************************
// Software registers (word index)
// ****************************************
`define DAP_REG_AW      3
`define DAP_REG_CTRL    3'h0
`define DAP_REG_ADDR_LO 3'h1
`define DAP_REG_ADDR_HI 3'h2
`define DAP_REG_CMD     3'h3
`define DAP_REG_WPAT    3'h4
`define DAP_REG_STRB_LO 3'h5
`define DAP_REG_STRB_HI 3'h6
`define DAP_REG_STATUS  3'h7
// CTRL bits
`define DAP_CTRL_WR 0
`define DAP_CTRL_RD 1
// CMD fields
`define DAP_CMD_LEN   7:0
`define DAP_CMD_SIZE  10:8
`define DAP_CMD_BURST 12:11
`define DAP_CMD_ID    18:13
`define DAP_CMD_LOCK  19
`define DAP_CMD_QOS   23:20
`define DAP_CMD_CACHE 27:24
`define DAP_CMD_APC   28
`define DAP_CMD_ALLS  29
`define DAP_CMD_COBUF 30
// STATUS bits
`define DAP_ST_BUSY   0
`define DAP_ST_WDONE  1
`define DAP_ST_RDONE  2
`define DAP_ST_RESP   4:3
`define DAP_ST_BID    10:5
`endif

// ### rtl/dap_pkg.sv
// Types shared by the DDR port master modules
`include "dap_defines.svh"
package dap_pkg;
   // ****************************************
   // Channel payloads
   // ****************************************
   typedef struct packed {
      logic [`DAP_ADDR_W-1:0]  addr;
      logic [1:0]              burst;
      logic [`DAP_ID_W-1:0]    id;
      logic [`DAP_LEN_W-1:0]   len;
      logic [`DAP_SIZE_W-1:0]  size;
      logic                    lock;
      logic [`DAP_QOS_W-1:0]   qos;
      logic                    apcmd;
      logic [`DAP_CACHE_W-1:0] cache;
      logic                    allstrb;
      logic                    cobuf;
   } dap_aw_t;

   typedef struct packed {
      logic [`DAP_ADDR_W-1:0] addr;
      logic [1:0]             burst;
      logic [`DAP_ID_W-1:0]   id;
      logic [`DAP_LEN_W-1:0]  len;
      logic [`DAP_SIZE_W-1:0] size;
      logic                   lock;
      logic [`DAP_QOS_W-1:0]  qos;
      logic                   apcmd;
   } dap_ar_t;

   typedef struct packed {
      logic [`DAP_DATA_W-1:0] data;
      logic [`DAP_STRB_W-1:0] strb;
      logic                   last;
   } dap_w_t;

   typedef struct packed {
      logic [`DAP_ID_W-1:0]   id;
      logic [`DAP_RESP_W-1:0] resp;
   } dap_b_t;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      DAP_IDLE  = 2'b00,
      DAP_WRITE = 2'b01,
      DAP_WRESP = 2'b10,
      DAP_READ  = 2'b11
   } dap_state_t;
endpackage : dap_pkg

// ### rtl/dap_sync.sv
// Two-flop synchroniser for inputs arriving from the link pins
`timescale 1ns/100ps
`include "dap_defines.svh"
module dap_sync #(
   parameter int W = `DAP_SYNC_W
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_reg;

   // First stage is read only by the second
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_reg <= '0;
         q_o    <= '0;
      end
      else
      begin
         s1_reg <= d_i;
         q_o    <= s1_reg;
      end
   end
endmodule : dap_sync

// ### rtl/dap_beat_gen.sv
// Write beat generator: data pattern, strobes and last flag per beat
`timescale 1ns/100ps
`include "dap_defines.svh"
module dap_beat_gen (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   nrst_i,
   // Control
   input  wire logic                   load_i,
   input  wire logic                   adv_i,
   input  wire logic [31:0]            pat_i,
   input  wire logic [`DAP_STRB_W-1:0] strb_i,
   input  wire logic                   full_i,
   input  wire logic [`DAP_LEN_W-1:0]  len_i,
   // Beat out
   output dap_pkg::dap_w_t             w_o
);
   logic [`DAP_LEN_W-1:0] beat_reg;
   logic [`DAP_LEN_W-1:0] beat_next;
   dap_pkg::dap_w_t       w_next;

   // Beat payload only moves on load or advance, so it holds while valid
   always_comb
   begin
      beat_next = beat_reg;
      w_next    = w_o;
      if (load_i || adv_i)
      begin
         beat_next   = load_i ? '0 : beat_reg + 8'h01;
         w_next.data = {`DAP_PAT_REP{pat_i + {24'h000000, beat_next}}};
         w_next.strb = full_i ? '1 : strb_i;
         w_next.last = (beat_next == len_i);
      end
   end

   // Beat registers
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         beat_reg <= '0;
         w_o      <= '0;
      end
      else
      begin
         beat_reg <= beat_next;
         w_o      <= w_next;
      end
   end
endmodule : dap_beat_gen

// ### rtl/dap_axi_host.sv
// AXI4 master that drives one port of a DDR controller
// Function
// - Write beats carry 512 data bits and a 64-bit byte strobe.
// - Write-last marks only the final beat of each write burst.
// - Write-valid only with valid data; device readies when it accepts.
// - Burst type 01 incrementing, 10 wrapping, on both address channels.
// - Both address channels carry a 33-bit first-transfer address.
// - Both address channels carry an 8-bit burst length.
// - Both address channels carry a 3-bit transfer size.
// - Address valid only with valid fields; ready per channel from device.
// - Both address channels carry a 6-bit transaction identifier.
// - Both address channels carry a lock-type bit.
// - Read address carries a QoS priority hint.
// - Write address carries a QoS priority hint.
// - Write address carries a 4-bit memory-type field.
// - Full-strobe writes are limited to 16 beats.
// - Port signals follow the port clock; low reset holds the port.
`timescale 1ns/100ps
`include "dap_defines.svh"
module dap_axi_host #(
   parameter int ACLK_HALF = `DAP_ACLK_HALF
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   nrst_i,
   // Software register port
   input  wire logic [`DAP_REG_AW-1:0] sw_addr_i,
   input  wire logic [31:0]            sw_wdata_i,
   input  wire logic                   sw_wr_i,
   input  wire logic                   sw_rd_i,
   output logic      [31:0]            sw_rdata_o,
   // Port clock and reset
   output logic                        aclk_o,
   output logic                        port_reset_n_o,
   // Write address channel
   output dap_pkg::dap_aw_t            aw_o,
   output logic                        awvalid_o,
   input  wire logic                   awready_i,
   // Write data channel
   output dap_pkg::dap_w_t             w_o,
   output logic                        wvalid_o,
   input  wire logic                   wready_i,
   // Read address channel
   output dap_pkg::dap_ar_t            ar_o,
   output logic                        arvalid_o,
   input  wire logic                   arready_i,
   // Write response channel
   input  wire logic                   bvalid_i,
   input  wire dap_pkg::dap_b_t        b_i,
   output logic                        bready_o
);
   localparam logic [`DAP_PH_W-1:0] LAST_PH = `DAP_PH_W'(2*ACLK_HALF-1);
   localparam logic [`DAP_PH_W-1:0] FALL_PH = `DAP_PH_W'(ACLK_HALF-1);

   // ****************************************
   // Functions
   // ****************************************
   // Only the two documented burst codes go out; others fall back to INCR
   function automatic logic [1:0] legal_burst(input logic [1:0] b);
      legal_burst = (b == `DAP_BURST_WRAP) ? `DAP_BURST_WRAP
                                           : `DAP_BURST_INCR;
   endfunction : legal_burst

   // ****************************************
   // Declarations
   // ****************************************
   dap_pkg::dap_state_t    state_reg, state_next;
   logic [`DAP_PH_W-1:0]   ph_reg, ph_next;
   logic                   aclk_next, prst_next;
   logic                   launch_reg, launch_next;
   logic                   awv_next, wv_next, arv_next, brdy_next;
   logic                   aw_hs_reg, aw_hs_next;
   logic                   w_hs_reg, w_hs_next;
   logic                   ar_hs_reg, ar_hs_next;
   logic                   b_hs_reg, b_hs_next;
   dap_pkg::dap_aw_t       aw_next;
   dap_pkg::dap_ar_t       ar_next;
   logic [31:0]            alo_reg, alo_next;
   logic                   ahi_reg, ahi_next;
   logic [31:0]            cmd_reg, cmd_next;
   logic [31:0]            pat_reg, pat_next;
   logic [63:0]            strb_reg, strb_next;
   logic                   wdone_reg, wdone_next;
   logic                   rdone_reg, rdone_next;
   dap_pkg::dap_b_t        bst_reg, bst_next;
   logic [31:0]            rdata_next;
   logic                   load, adv, rise_ev, fall_ev;
   logic [`DAP_LEN_W-1:0]  len_eff;
   logic                   awrdy_s, wrdy_s, arrdy_s, bvld_s;
   dap_pkg::dap_b_t        b_s;

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Pins come from another timing domain; all flags lag by two cycles
   dap_sync #(.W(`DAP_SYNC_W)) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    ({awready_i, wready_i, arready_i, bvalid_i, b_i}),
      .q_o    ({awrdy_s, wrdy_s, arrdy_s, bvld_s, b_s})
   );

   // ****************************************
   // Write beat generator
   // ****************************************
   dap_beat_gen u_beat (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .load_i (load),
      .adv_i  (adv),
      .pat_i  (pat_reg),
      .strb_i (strb_reg),
      .full_i (cmd_reg[`DAP_CMD_ALLS]),
      .len_i  (aw_next.len),             // Length of the burst being loaded
      .w_o    (w_o)
   );

   // Port clock edges: sample at the rise, drive at the fall
   assign rise_ev = (ph_reg == LAST_PH);
   assign fall_ev = (ph_reg == FALL_PH);
   assign len_eff = (cmd_reg[`DAP_CMD_ALLS] &&
                     cmd_reg[`DAP_CMD_LEN] > `DAP_ALLSTRB_MAX_LEN)
                    ? `DAP_ALLSTRB_MAX_LEN : cmd_reg[`DAP_CMD_LEN];

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      ph_next     = (ph_reg == LAST_PH) ? '0 : ph_reg + 4'h1;
      aclk_next   = (ph_next < `DAP_PH_W'(ACLK_HALF));
      prst_next   = 1'b1;
      state_next  = state_reg;
      launch_next = launch_reg;
      awv_next    = awvalid_o;
      wv_next     = wvalid_o;
      arv_next    = arvalid_o;
      brdy_next   = bready_o;
      aw_hs_next  = aw_hs_reg;
      w_hs_next   = w_hs_reg;
      ar_hs_next  = ar_hs_reg;
      b_hs_next   = b_hs_reg;
      aw_next     = aw_o;
      ar_next     = ar_o;
      alo_next    = alo_reg;
      ahi_next    = ahi_reg;
      cmd_next    = cmd_reg;
      pat_next    = pat_reg;
      strb_next   = strb_reg;
      wdone_next  = wdone_reg;
      rdone_next  = rdone_reg;
      bst_next    = bst_reg;
      load        = 1'b0;
      adv         = 1'b0;
      // Software writes; done flags are write-one-to-clear
      if (sw_wr_i)
      begin
         case (sw_addr_i)
            `DAP_REG_ADDR_LO: alo_next  = sw_wdata_i;
            `DAP_REG_ADDR_HI: ahi_next  = sw_wdata_i[0];
            `DAP_REG_CMD:     cmd_next  = sw_wdata_i;
            `DAP_REG_WPAT:    pat_next  = sw_wdata_i;
            `DAP_REG_STRB_LO: strb_next[31:0]  = sw_wdata_i;
            `DAP_REG_STRB_HI: strb_next[63:32] = sw_wdata_i;
            `DAP_REG_STATUS:
            begin
               if (sw_wdata_i[`DAP_ST_WDONE])
                  wdone_next = 1'b0;
               if (sw_wdata_i[`DAP_ST_RDONE])
                  rdone_next = 1'b0;
            end
            default: ;
         endcase
      end
      // Handshakes are judged at the port clock rise
      if (rise_ev)
      begin
         if (awvalid_o && awrdy_s)
            aw_hs_next = 1'b1;
         if (wvalid_o && wrdy_s)
            w_hs_next = 1'b1;
         if (arvalid_o && arrdy_s)
            ar_hs_next = 1'b1;
         if (bready_o && bvld_s)
         begin
            b_hs_next = 1'b1;
            bst_next  = b_s;
         end
      end
      case (state_reg)
         dap_pkg::DAP_IDLE:
         begin
            // Start requests while busy are ignored
            if (sw_wr_i && sw_addr_i == `DAP_REG_CTRL)
            begin
               aw_next.addr    = {ahi_reg, alo_reg};
               aw_next.burst   = legal_burst(cmd_reg[`DAP_CMD_BURST]);
               aw_next.id      = cmd_reg[`DAP_CMD_ID];
               aw_next.len     = len_eff;
               aw_next.size    = cmd_reg[`DAP_CMD_SIZE];
               aw_next.lock    = cmd_reg[`DAP_CMD_LOCK];
               aw_next.qos     = cmd_reg[`DAP_CMD_QOS];
               aw_next.apcmd   = cmd_reg[`DAP_CMD_APC];
               aw_next.cache   = cmd_reg[`DAP_CMD_CACHE];
               aw_next.allstrb = cmd_reg[`DAP_CMD_ALLS];
               aw_next.cobuf   = cmd_reg[`DAP_CMD_COBUF];
               ar_next.addr    = {ahi_reg, alo_reg};
               ar_next.burst   = legal_burst(cmd_reg[`DAP_CMD_BURST]);
               ar_next.id      = cmd_reg[`DAP_CMD_ID];
               ar_next.len     = cmd_reg[`DAP_CMD_LEN];
               ar_next.size    = cmd_reg[`DAP_CMD_SIZE];
               ar_next.lock    = cmd_reg[`DAP_CMD_LOCK];
               ar_next.qos     = cmd_reg[`DAP_CMD_QOS];
               ar_next.apcmd   = cmd_reg[`DAP_CMD_APC];
               if (sw_wdata_i[`DAP_CTRL_WR])
               begin
                  state_next = dap_pkg::DAP_WRITE;
                  load       = 1'b1;
               end
               else if (sw_wdata_i[`DAP_CTRL_RD])
                  state_next = dap_pkg::DAP_READ;
            end
         end
         dap_pkg::DAP_WRITE:
         begin
            if (fall_ev && !launch_reg)
            begin
               launch_next = 1'b1;
               awv_next    = 1'b1;
               wv_next     = 1'b1;
            end
            else if (fall_ev)
            begin
               // Valid drops only after its transfer completed
               if (aw_hs_reg)
               begin
                  awv_next   = 1'b0;
                  aw_hs_next = 1'b0;
               end
               if (w_hs_reg)
               begin
                  w_hs_next = 1'b0;
                  if (w_o.last)
                     wv_next = 1'b0;
                  else
                     adv = 1'b1;
               end
               if (!awv_next && !wv_next)
               begin
                  state_next = dap_pkg::DAP_WRESP;
                  brdy_next  = 1'b1;
               end
            end
         end
         dap_pkg::DAP_WRESP:
         begin
            // Ready stays up until the response is taken
            if (fall_ev && b_hs_reg)
            begin
               brdy_next   = 1'b0;
               b_hs_next   = 1'b0;
               wdone_next  = 1'b1;
               launch_next = 1'b0;
               state_next  = dap_pkg::DAP_IDLE;
            end
         end
         dap_pkg::DAP_READ:
         begin
            if (fall_ev && !launch_reg)
            begin
               launch_next = 1'b1;
               arv_next    = 1'b1;
            end
            else if (fall_ev && ar_hs_reg)
            begin
               arv_next    = 1'b0;
               ar_hs_next  = 1'b0;
               rdone_next  = 1'b1;
               launch_next = 1'b0;
               state_next  = dap_pkg::DAP_IDLE;
            end
         end
         default: state_next = dap_pkg::DAP_IDLE;
      endcase
   end

   // Read mux; data stand for one cycle only
   always_comb
   begin
      rdata_next = 32'h00000000;
      if (sw_rd_i)
      begin
         case (sw_addr_i)
            `DAP_REG_ADDR_LO: rdata_next = alo_reg;
            `DAP_REG_ADDR_HI: rdata_next = {31'h0, ahi_reg};
            `DAP_REG_CMD:     rdata_next = cmd_reg;
            `DAP_REG_WPAT:    rdata_next = pat_reg;
            `DAP_REG_STRB_LO: rdata_next = strb_reg[31:0];
            `DAP_REG_STRB_HI: rdata_next = strb_reg[63:32];
            `DAP_REG_STATUS:
            begin
               rdata_next[`DAP_ST_BUSY]  = (state_reg != dap_pkg::DAP_IDLE);
               rdata_next[`DAP_ST_WDONE] = wdone_reg;
               rdata_next[`DAP_ST_RDONE] = rdone_reg;
               rdata_next[`DAP_ST_RESP]  = bst_reg.resp;
               rdata_next[`DAP_ST_BID]   = bst_reg.id;
            end
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg      <= dap_pkg::DAP_IDLE;
         ph_reg         <= '0;
         aclk_o         <= 1'b0;
         port_reset_n_o <= 1'b0;
         launch_reg     <= 1'b0;
         awvalid_o      <= 1'b0;
         wvalid_o       <= 1'b0;
         arvalid_o      <= 1'b0;
         bready_o       <= 1'b0;
         aw_hs_reg      <= 1'b0;
         w_hs_reg       <= 1'b0;
         ar_hs_reg      <= 1'b0;
         b_hs_reg       <= 1'b0;
         aw_o           <= '0;
         ar_o           <= '0;
         alo_reg        <= '0;
         ahi_reg        <= 1'b0;
         cmd_reg        <= '0;
         pat_reg        <= '0;
         strb_reg       <= '0;
         wdone_reg      <= 1'b0;
         rdone_reg      <= 1'b0;
         bst_reg        <= '0;
         sw_rdata_o     <= '0;
      end
      else
      begin
         state_reg      <= state_next;
         ph_reg         <= ph_next;
         aclk_o         <= aclk_next;
         port_reset_n_o <= prst_next;
         launch_reg     <= launch_next;
         awvalid_o      <= awv_next;
         wvalid_o       <= wv_next;
         arvalid_o      <= arv_next;
         bready_o       <= brdy_next;
         aw_hs_reg      <= aw_hs_next;
         w_hs_reg       <= w_hs_next;
         ar_hs_reg      <= ar_hs_next;
         b_hs_reg       <= b_hs_next;
         aw_o           <= aw_next;
         ar_o           <= ar_next;
         alo_reg        <= alo_next;
         ahi_reg        <= ahi_next;
         cmd_reg        <= cmd_next;
         pat_reg        <= pat_next;
         strb_reg       <= strb_next;
         wdone_reg      <= wdone_next;
         rdone_reg      <= rdone_next;
         bst_reg        <= bst_next;
         sw_rdata_o     <= rdata_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_aw_valid_hold: assert property ($fell(awvalid_o) |-> $past(aw_hs_reg))
      else $error("write address valid dropped early");
   a_ar_valid_hold: assert property ($fell(arvalid_o) |-> $past(ar_hs_reg))
      else $error("read address valid dropped early");
   a_w_last_end: assert property
      ($fell(wvalid_o) |-> $past(w_hs_reg) && $past(w_o.last))
      else $error("write data ended off the last beat");
   a_aw_payload_hold: assert property
      (awvalid_o && $past(awvalid_o) |-> $stable(aw_o))
      else $error("write address changed while valid");
   a_drive_at_fall: assert property
      ($changed(awvalid_o) || $changed(wvalid_o) || $changed(arvalid_o)
       |-> !aclk_o && $past(aclk_o))
      else $error("valid changed away from port clock fall");
   a_allstrb_len: assert property
      (awvalid_o && aw_o.allstrb |-> aw_o.len <= `DAP_ALLSTRB_MAX_LEN)
      else $error("full strobe burst too long");
   a_allstrb_strb: assert property
      (wvalid_o && aw_o.allstrb |-> &w_o.strb)
      else $error("full strobe hint without full strobes");
   a_burst_legal: assert property
      (awvalid_o |-> aw_o.burst inside {`DAP_BURST_INCR, `DAP_BURST_WRAP})
      else $error("illegal write burst type");
   a_bready_hold: assert property ($fell(bready_o) |-> $past(b_hs_reg))
      else $error("response ready dropped before response");

   c_write_done: cover property ($fell(bready_o));
   c_read_done: cover property ($fell(arvalid_o));
   c_wrap_write: cover property
      (awvalid_o && aw_o.burst == `DAP_BURST_WRAP);
   c_full_strobe: cover property (wvalid_o && aw_o.allstrb && w_o.last);
endmodule : dap_axi_host

// ### bench/dap_dev_model.sv
// Behavioural DDR port slave facing the AXI4 master
`timescale 1ns/100ps
module dap_dev_model (
   // Port clock and reset
   input  wire logic             aclk_i,
   input  wire logic             rst_n_i,
   // Address and data channels
   input  wire dap_pkg::dap_aw_t aw_i,
   input  wire logic             awvalid_i,
   output logic                  awready_o,
   input  wire dap_pkg::dap_w_t  w_i,
   input  wire logic             wvalid_i,
   output logic                  wready_o,
   input  wire dap_pkg::dap_ar_t ar_i,
   input  wire logic             arvalid_i,
   output logic                  arready_o,
   // Write response
   output logic                  bvalid_o,
   output dap_pkg::dap_b_t       b_o,
   input  wire logic             bready_i
);
   dap_pkg::dap_aw_t aw_seen;
   dap_pkg::dap_ar_t ar_seen;
   dap_pkg::dap_w_t  w_seen;
   int               beats;
   int               lasts;
   // Ready trails valid by a port clock, so the host must hold its offer
   always @(posedge aclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         {awready_o, wready_o, arready_o, bvalid_o} <= 4'h0;
         b_o <= '0;
         beats <= 0;
         lasts <= 0;
      end
      else
      begin
         awready_o <= awvalid_i & ~awready_o;
         arready_o <= arvalid_i & ~arready_o;
         wready_o <= wvalid_i & ~(wready_o & w_i.last);
         if (awvalid_i & awready_o)
            aw_seen <= aw_i;
         if (arvalid_i & arready_o)
            ar_seen <= ar_i;
         if (wvalid_i & wready_o)
         begin
            beats <= beats + 1;
            lasts <= lasts + int'(w_i.last);
            w_seen <= w_i;
         end
         // Response held until taken, then the bus shows garbage
         if (wvalid_i & wready_o & w_i.last)
         begin
            bvalid_o <= 1'b1;
            b_o <= '{id: aw_i.id, resp: 2'h1};
         end
         else if (bvalid_o & bready_i)
         begin
            bvalid_o <= 1'b0;
            b_o <= ~b_o;
         end
      end
   end
endmodule : dap_dev_model

// ### bench/dap_axi_host_tb.sv
// Self-checking bench for the AXI4 DDR port master
`timescale 1ns/100ps
module dap_axi_host_tb;
   logic clk_i, nrst_i, sw_wr_i, sw_rd_i, aclk_o, port_reset_n_o;
   logic awvalid_o, awready_i, wvalid_o, wready_i, arvalid_o, arready_i;
   logic bvalid_i, bready_o;
   logic [2:0] sw_addr_i;
   logic [31:0] sw_wdata_i, sw_rdata_o, rd_v;
   dap_pkg::dap_aw_t aw_o;
   dap_pkg::dap_w_t w_o;
   dap_pkg::dap_ar_t ar_o;
   dap_pkg::dap_b_t b_i;
   int n_mismatch = 0;
   int samples_checked = 0;
   int b0;
   dap_axi_host i_dap_axi_host (.*);
   dap_dev_model i_dap_dev_model (.aclk_i(aclk_o), .rst_n_i(port_reset_n_o),
      .aw_i(aw_o), .awvalid_i(awvalid_o), .awready_o(awready_i), .w_i(w_o),
      .wvalid_i(wvalid_o), .wready_o(wready_i), .ar_i(ar_o),
      .arvalid_i(arvalid_o), .arready_o(arready_i), .bvalid_o(bvalid_i),
      .b_o(b_i), .bready_i(bready_o));
   task automatic check(input logic [639:0] seen, exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_i);
      sw_addr_i <= a;
      sw_wdata_i <= d;
      sw_wr_i <= 1'b1;
      @(posedge clk_i);
      sw_wr_i <= 1'b0;
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge clk_i);
      sw_addr_i <= a;
      sw_rd_i <= 1'b1;
      @(posedge clk_i);
      sw_rd_i <= 1'b0;
      @(negedge clk_i);
      rd_v = sw_rdata_o;
   endtask : rd
   task automatic go(input logic [32:0] a, input logic [31:0] c, p,
                     input logic [63:0] s, input logic [1:0] k);
      b0 = i_dap_dev_model.beats;
      wr(1, a[31:0]);
      wr(2, {31'h0, a[32]});
      wr(3, c);
      wr(4, p);
      wr(5, s[31:0]);
      wr(6, s[63:32]);
      wr(0, {30'h0, k});
      // Poll status a bounded number of times for the done flag
      for (int i = 0; i < 120; i++)
      begin
         rd(7);
         if (rd_v[k] === 1'b1)
            break;
      end
      check(rd_v[k], 1'b1);
   endtask : go
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial
   begin
      #2000000 n_mismatch++;
      close_out;
   end
   initial
   begin
      {nrst_i, sw_wr_i, sw_rd_i, sw_addr_i, sw_wdata_i} = '0;
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(7);
      check(rd_v, 32'h0);
      check(port_reset_n_o, 1'b1);
      // Odd burst code goes out as incrementing, four beats
      go(33'h1_2345_6780, 32'h5B9D_5E03, 32'hA5A5_0010, 64'hF0F0_0FF0_1234_8001, 2'h1);
      check(i_dap_dev_model.aw_seen, {33'h1_2345_6780, 2'h1, 6'h2A, 8'h03, 3'h6, 5'h19, 1'b1, 4'hB, 2'h1});
      check(i_dap_dev_model.beats - b0, 4);
      check(i_dap_dev_model.lasts, 1);
      check(i_dap_dev_model.w_seen, {{16{32'hA5A5_0013}}, 64'hF0F0_0FF0_1234_8001, 1'b1});
      check(rd_v[10:3], {6'h2A, 2'h1});
      wr(7, 32'h2);
      rd(7);
      check(rd_v[1], 1'b0);
      // Full-strobe wrapping write clamps twenty-one beats to sixteen
      go(33'h0_0000_0040, 32'h2000_B614, 32'h0, 64'h1, 2'h1);
      check(i_dap_dev_model.aw_seen.burst, 2'h2);
      check(i_dap_dev_model.beats - b0, 16);
      check(i_dap_dev_model.aw_seen.len, 8'h0F);
      check(i_dap_dev_model.w_seen.strb, {64{1'b1}});
      go(33'h0_0000_0100, 32'h10C2_3507, 32'h0, 64'h0, 2'h2);
      check(i_dap_dev_model.ar_seen, {33'h100, 2'h2, 6'h11, 8'h07, 3'h5, 1'b0, 4'hC, 1'b1});
      close_out;
   end
endmodule : dap_axi_host_tb
